// ---- bench/cpe_host.sv ----
// cpe_host: serial host that reads and writes the engine's registers
// assumes: mode 0 frames of 32 bits, 80 ns link clock that rests low between frames
`timescale 1ns/10ps
module cpe_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  // idle link: clock parked low, chip select high
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame; keep leaves chip select low so the next frame runs without it
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata, input bit keep,
    output logic [15:0] rdata);
    logic [31:0] sh;
    sh = {cmd, 8'h00, wdata};
    rdata = 16'h0000;
    #3;
    o_cs_n = 1'b0;
    for (int b = 31; b >= 0; b--)
    begin
      o_mosi = sh[b];
      #40;
      o_sclk = 1'b1;
      // undriven data reads as unknown so it can never pass a compare
      if (b < 16)
        rdata = {rdata[14:0], i_miso_oe ? i_miso : 1'bx};
      #40;
      o_sclk = 1'b0;
    end
    o_mosi = ~o_mosi; // released line shows the inverse of its last bit
    #20;
    if (!keep)
      o_cs_n = 1'b1;
    #60;
  endtask
endmodule

// ---- bench/test_current_power_calc_engine.sv ----
// test_current_power_calc_engine: self-checking bench of the calc engine
// assumes: cpe_host drives the link, a behavioural converter lives here
`timescale 1ns/10ps
module test_current_power_calc_engine;
  import cpe_pkg::*;
  logic i_clk; // core clock
  logic i_rst_n; // sync reset
  logic sclk, cs_n, mosi, miso, miso_oe; // serial link
  logic [1:0] o_adc_sel;
  logic o_adc_start;
  logic i_adc_done;
  logic [DW-1:0] i_adc_data;
  logic signed [DW-1:0] o_current, o_power;
  logic o_conv_ready, o_busy, o_shunt_range_select;
  logic [1:0] o_mode;
  int fails, n_checks;
  int samp; // samples finished in this run
  int lat, gap; // converter countdown, cycles since last done
  int quiet; // cycles since chip select was last low, saturates at 8
  logic armed; // a done was seen, so the next start is timed
  logic [1:0] last_sel; // input of the conversion in flight
  logic [15:0] last_cur, rd;
  localparam logic [15:0] BUS_V = 16'h0800; // fixed bus result
  localparam logic [15:0] CAL_V = 16'h1000; // calibration used
  ////////////////////////////////////////////////////////////////////////////
  cpe_engine cpe_engine_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .o_adc_sel(o_adc_sel),
    .o_adc_start(o_adc_start), .i_adc_done(i_adc_done), .i_adc_data(i_adc_data),
    .o_current(o_current), .o_power(o_power), .o_conv_ready(o_conv_ready), .o_busy(o_busy),
    .o_mode(o_mode), .o_shunt_range_select(o_shunt_range_select));
  cpe_host cpe_host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso),
    .i_miso_oe(miso_oe));
  // core clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // behavioural converter: three cycles per conversion, data by mux input
  always @(negedge i_clk)
  begin
    logic fire;
    fire = 1'b0;
    gap++;
    // a frame may restart the sequence, and the write lands just before chip
    // select rises, so start timing is not fixed during a frame or shortly after
    if (cs_n !== 1'b1)
      quiet = 0;
    else if (quiet < 8)
      quiet++;
    if (quiet < 8)
      armed = 1'b0;
    if (o_adc_start === 1'b1)
    begin
      if (armed)
      begin
        chk("start gap", 16'h0002, 16'(gap));
        chk("mux order", 16'(last_sel == SEL_TEMP ? SEL_SHUNT : last_sel + 2'h1),
          16'(o_adc_sel));
      end
      armed = 1'b0;
      last_sel = o_adc_sel;
      lat = 3;
    end
    else if (lat > 0)
    begin
      lat--;
      fire = (lat == 0);
    end
    i_adc_done = fire;
    if (fire)
    begin
      i_adc_data = (last_sel == SEL_SHUNT) ? 16'(256 * (samp + 1)) :
        (last_sel == SEL_BUS) ? BUS_V : 16'h0123;
      armed = 1'b1;
      gap = 0;
      if (last_sel == SEL_TEMP)
        samp++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // average current or power over one run, shunt grows by 256 each sample
  function automatic logic [15:0] exp_avg(input logic [15:0] cfg, input bit pwr);
    int cur, sum;
    sum = 0;
    for (int k = 0; k < (1 << cfg[11:8]); k++)
    begin
      cur = (256 * (k + 1) * int'(CAL_V)) >>>
        (CUR_SHIFT + (cfg[CFG_RANGE_BIT] ? RANGE_SHIFT : 0));
      sum += pwr ? (cur * int'(BUS_V)) >>> PWR_SHIFT : cur;
    end
    return 16'(sum >>> cfg[11:8]);
  endfunction
  task automatic spi(input logic [2:0] idx, input bit wr, input logic [15:0] d, input bit keep);
    cpe_host_i.xfer({wr, 4'h0, idx}, d, keep, rd);
  endtask
  // bounded wait for a published run
  task automatic wait_ready();
    int t;
    t = 0;
    while (o_conv_ready !== 1'b1 && t < 1000)
    begin
      @(negedge i_clk);
      t++;
    end
    chk("run finished", 16'h0001, 16'(o_conv_ready));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_zero_cal();
    wait_ready();
    chk("current cal zero", 16'h0000, o_current);
    chk("power cal zero", 16'h0000, o_power);
    chk("mode after reset", 16'(MODE_CONT), 16'(o_mode));
  endtask
  // stop first so that the new calibration never reaches the outputs
  task automatic t_stop();
    spi(A_CFG, 1'b1, 16'h0000, 1'b0);
    spi(A_CAL, 1'b1, CAL_V, 1'b0);
    spi(A_CAL, 1'b0, 16'h0000, 1'b0);
    chk("calibration readback", CAL_V, rd);
    chk("mode off", 16'(MODE_OFF), 16'(o_mode));
    chk("busy off", 16'h0000, 16'(o_busy));
    chk("current kept", 16'h0000, o_current);
  endtask
  // one triggered run, then read both results with chip select held low
  task automatic t_run(input logic [15:0] cfg);
    int t;
    // the engine is idle here, so the count is cleared before the write restarts it
    samp = 0;
    spi(A_CFG, 1'b1, cfg, 1'b0);
    chk("ready after write", 16'h0000, 16'(o_conv_ready));
    if (cfg[11:8] != 4'h0)
    begin
      t = 0;
      while (samp < 2 && t < 1000)
      begin
        @(negedge i_clk);
        t++;
      end
      chk("current mid run", last_cur, o_current);
    end
    wait_ready();
    last_cur = exp_avg(cfg, 1'b0);
    chk("current", last_cur, o_current);
    chk("power", exp_avg(cfg, 1'b1), o_power);
    chk("range select", 16'(cfg[CFG_RANGE_BIT]), 16'(o_shunt_range_select));
    spi(A_CUR, 1'b0, 16'h0000, 1'b1);
    chk("current over link", last_cur, rd);
    spi(A_PWR, 1'b0, 16'h0000, 1'b0);
    chk("power over link", exp_avg(cfg, 1'b1), rd);
    spi(A_SHUNT, 1'b0, 16'h0000, 1'b0);
    chk("shunt over link", 16'(256 << cfg[11:8]), rd);
    chk("busy after trigger", 16'h0000, 16'(o_busy));
  endtask
  task automatic t_cont();
    samp = 0;
    spi(A_CFG, 1'b1, 16'h0002, 1'b0);
    wait_ready();
    chk("current continuous", exp_avg(16'h0002, 1'b0), o_current);
    chk("busy continuous", 16'h0001, 16'(o_busy));
    chk("mode continuous", 16'(MODE_CONT), 16'(o_mode));
    spi(A_BUS, 1'b0, 16'h0000, 1'b1);
    chk("bus over link", BUS_V, rd);
    spi(A_TEMP, 1'b0, 16'h0000, 1'b1);
    chk("temp over link", 16'h0123, rd);
    spi(A_CFG, 1'b0, 16'h0000, 1'b1);
    chk("config over link", 16'h0002, rd);
    spi(3'h7, 1'b0, 16'h0000, 1'b0);
    chk("status over link", 16'h0003, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog far beyond the roughly 55 microseconds the tests need
  initial
  begin
    #400000;
    fails++;
    end_sim();
  end
  initial
  begin
    i_rst_n = 1'b0;
    i_adc_done = 1'b0;
    i_adc_data = 16'h0000;
    fails = 0;
    n_checks = 0;
    samp = 0;
    lat = 0;
    gap = 0;
    quiet = 0;
    armed = 1'b0;
    last_sel = SEL_SHUNT;
    last_cur = 16'h0000;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    t_zero_cal();
    t_stop();
    t_run(16'h0201);
    t_run(16'h0201);
    t_run(16'h0011);
    t_cont();
    end_sim();
  end
endmodule

// ---- core/cpe_engine.sv ----
// cpe_engine: background current and power engine with averaging
// assumes: one converter on i_clk with start/done, host on a serial link
// Functional notes
// - calculate only after shunt and bus results
// - power uses the current formed for the same sample, latest bus
// - zero calibration forces zero power
// - averaging above one keeps results internal
// - add each sample into the accumulator
// - publish averages once the run completes
// - arithmetic never delays the conversion sequence
// - one converter, inputs taken through a mux
// - registers reachable over four-wire serial port
// - software picks continuous or triggered operation
// - shunt weight 5 uV or 1.25 uV
`timescale 1ns/10ps
module cpe_engine
  import cpe_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [1:0] o_adc_sel,
  output logic o_adc_start,
  input wire logic i_adc_done,
  input wire logic [DW-1:0] i_adc_data,
  output logic signed [DW-1:0] o_current,
  output logic signed [DW-1:0] o_power,
  output logic o_conv_ready,
  output logic o_busy,
  output logic [1:0] o_mode,
  output logic o_shunt_range_select
);
  logic link_hold, next_hold; // holds the link side while in reset
  logic [7:0] cmd; // command byte from the link
  logic req_tgl, wr_tgl; // link event toggles
  logic [DW-1:0] wdata; // write word from the link
  logic [2:0] req_s, next_req_s, wr_s, next_wr_s; // 3-stage syncs
  logic ack, next_ack, wr_seen, next_wr_seen;
  logic [DW-1:0] rdata, next_rdata; // read word held for the link
  logic [DW-1:0] cfg, next_cfg, cal, next_cal;
  logic rd_ev, wr_ev, restart; // one-cycle host events
  logic [3:0] avg_log; // log2 of the averaging count
  cpe_seq_t state, next_state;
  logic [1:0] next_sel;
  logic next_start;
  logic [NW-1:0] samp, next_samp, n, next_n, n_max;
  logic samp_last, n_last, done_now, bus_done;
  logic [DW-1:0] shunt_raw, next_shunt, bus_raw, next_bus, temp_raw, next_temp;
  logic go1, next_go1, go2, next_go2; // calc pipeline strobes
  logic signed [DW-1:0] cur_q, next_cur_q, cur_comb, pwr_comb;
  logic signed [DW-1:0] next_cur_out, next_pwr_out;
  logic signed [32:0] prod_c, prod_p, sh_c, sh_p;
  logic signed [ACC_W-1:0] acc_c, next_acc_c, acc_p, next_acc_p;
  logic signed [ACC_W-1:0] sum_c, sum_p, avg_c, avg_p;
  logic next_rdy;

  cpe_spi u_spi (
    .i_sclk(i_sclk),
    .i_hold(link_hold),
    .i_clr_cnt(i_cs_n | link_hold),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .o_cmd(cmd),
    .o_req_tgl(req_tgl),
    .i_ack_tgl(ack),
    .i_rdata(rdata),
    .o_wdata(wdata),
    .o_wr_tgl(wr_tgl)
  );

  //////////////////////////////////////////////////////////////////////
  // host side: event syncs, read mux, configuration
  always_comb
  begin
    next_hold = ~i_rst_n;
    next_req_s = {req_s[1:0], req_tgl};
    next_wr_s = {wr_s[1:0], wr_tgl};
    // cmd and wdata are quiet for many link bits after their toggle
    rd_ev = (req_s[1] == req_s[2]) && (req_s[2] != ack);
    wr_ev = (wr_s[1] == wr_s[2]) && (wr_s[2] != wr_seen);
    restart = wr_ev && (cmd[2:0] == A_CFG);
    next_ack = rd_ev ? req_s[2] : ack;
    next_wr_seen = wr_ev ? wr_s[2] : wr_seen;
    next_rdata = rdata;
    if (rd_ev)
    begin
      case (cmd[2:0])
        A_CFG: next_rdata = cfg;
        A_CAL: next_rdata = cal;
        A_CUR: next_rdata = o_current;
        A_PWR: next_rdata = o_power;
        A_SHUNT: next_rdata = shunt_raw;
        A_BUS: next_rdata = bus_raw;
        A_TEMP: next_rdata = temp_raw;
        default: next_rdata = {14'h0000, o_busy, o_conv_ready};
      endcase
    end
    next_cfg = restart ? wdata : cfg;
    next_cal = (wr_ev && cmd[2:0] == A_CAL) ? wdata : cal;
  end

  always_ff @(posedge i_clk)
  begin
    link_hold <= next_hold;
    if (!i_rst_n)
    begin
      req_s <= 3'h0;
      wr_s <= 3'h0;
      ack <= 1'b0;
      wr_seen <= 1'b0;
      rdata <= 16'h0000;
      cfg <= CFG_RST;
      cal <= CAL_RST;
    end
    else
    begin
      req_s <= next_req_s;
      wr_s <= next_wr_s;
      ack <= next_ack;
      wr_seen <= next_wr_seen;
      rdata <= next_rdata;
      cfg <= next_cfg;
      cal <= next_cal;
    end
  end

  assign o_mode = cfg[CFG_MODE_LSB+:2];
  assign o_shunt_range_select = cfg[CFG_RANGE_BIT];
  // oversized counts saturate at 1024 samples
  assign avg_log = (cfg[CFG_AVG_LSB+:4] > AVG_LOG_MAX) ? AVG_LOG_MAX : cfg[CFG_AVG_LSB+:4];
  assign n_max = NW'((12'h001 << avg_log) - 12'h001);
  assign done_now = (state == ST_WAIT) && i_adc_done;
  assign bus_done = done_now && (o_adc_sel == SEL_BUS);
  assign samp_last = (samp == n_max);
  assign n_last = (n == n_max);
  assign o_busy = (state != ST_IDLE);

  //////////////////////////////////////////////////////////////////////
  // sequencer: shunt, bus, temperature in turn on the one converter;
  // it never looks at the calc pipeline, so timing is the same either way
  always_comb
  begin
    next_state = state;
    next_sel = o_adc_sel;
    next_start = 1'b0;
    next_samp = samp;
    case (state)
      ST_IDLE:
      begin
        if (o_mode[1])
        begin
          next_state = ST_START;
          next_sel = SEL_SHUNT;
          next_samp = {NW{1'b0}};
        end
      end
      ST_START:
      begin
        next_start = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (i_adc_done)
        begin
          next_state = ST_START;
          case (o_adc_sel)
            SEL_SHUNT: next_sel = SEL_BUS;
            SEL_BUS: next_sel = SEL_TEMP;
            default:
            begin
              next_sel = SEL_SHUNT;
              next_samp = samp_last ? {NW{1'b0}} : samp + NW'(1);
              if (samp_last && !o_mode[1])
              begin
                next_state = ST_IDLE;
              end
            end
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (restart) // a config write aborts, and restarts unless mode is off
    begin
      next_state = (wdata[CFG_MODE_LSB+:2] != MODE_OFF) ? ST_START : ST_IDLE;
      next_sel = SEL_SHUNT;
      next_samp = {NW{1'b0}};
      next_start = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ST_IDLE;
      o_adc_sel <= SEL_SHUNT;
      o_adc_start <= 1'b0;
      samp <= {NW{1'b0}};
    end
    else
    begin
      state <= next_state;
      o_adc_sel <= next_sel;
      o_adc_start <= next_start;
      samp <= next_samp;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // calc pipeline: go1 forms current, go2 forms power and accumulates
  assign prod_c = $signed(shunt_raw) * $signed({1'b0, cal});
  assign sh_c = prod_c >>> (o_shunt_range_select ? CUR_SHIFT + RANGE_SHIFT : CUR_SHIFT);
  assign cur_comb = sh_c[DW-1:0];
  assign prod_p = cur_q * $signed({1'b0, bus_raw});
  assign sh_p = prod_p >>> PWR_SHIFT;
  assign pwr_comb = (cal == 16'h0000) ? 16'sh0000 : sh_p[DW-1:0];
  assign sum_c = acc_c + {{(ACC_W-DW){cur_q[DW-1]}}, cur_q};
  assign sum_p = acc_p + {{(ACC_W-DW){pwr_comb[DW-1]}}, pwr_comb};
  assign avg_c = sum_c >>> avg_log;
  assign avg_p = sum_p >>> avg_log;

  always_comb
  begin
    next_shunt = shunt_raw;
    next_bus = bus_raw;
    next_temp = temp_raw;
    next_go1 = bus_done;
    next_go2 = go1;
    next_cur_q = go1 ? cur_comb : cur_q;
    next_acc_c = acc_c;
    next_acc_p = acc_p;
    next_n = n;
    next_cur_out = o_current;
    next_pwr_out = o_power;
    next_rdy = o_conv_ready;
    if (done_now)
    begin
      case (o_adc_sel)
        SEL_SHUNT: next_shunt = i_adc_data;
        SEL_BUS: next_bus = i_adc_data;
        default: next_temp = i_adc_data;
      endcase
    end
    if (go2)
    begin
      if (n_last)
      begin
        next_cur_out = avg_c[DW-1:0];
        next_pwr_out = avg_p[DW-1:0];
        next_acc_c = {ACC_W{1'b0}};
        next_acc_p = {ACC_W{1'b0}};
        next_n = {NW{1'b0}};
        next_rdy = 1'b1;
      end
      else
      begin
        next_acc_c = sum_c;
        next_acc_p = sum_p;
        next_n = n + NW'(1);
      end
    end
    if (restart) // drop partial run; a publish in this cycle still flags
    begin
      next_acc_c = {ACC_W{1'b0}};
      next_acc_p = {ACC_W{1'b0}};
      next_n = {NW{1'b0}};
      next_go1 = 1'b0;
      next_go2 = 1'b0;
      if (!(go2 && n_last))
      begin
        next_rdy = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      shunt_raw <= 16'h0000;
      bus_raw <= 16'h0000;
      temp_raw <= 16'h0000;
      go1 <= 1'b0;
      go2 <= 1'b0;
      cur_q <= 16'sh0000;
      acc_c <= {ACC_W{1'b0}};
      acc_p <= {ACC_W{1'b0}};
      n <= {NW{1'b0}};
      o_current <= 16'sh0000;
      o_power <= 16'sh0000;
      o_conv_ready <= 1'b0;
    end
    else
    begin
      shunt_raw <= next_shunt;
      bus_raw <= next_bus;
      temp_raw <= next_temp;
      go1 <= next_go1;
      go2 <= next_go2;
      cur_q <= next_cur_q;
      acc_c <= next_acc_c;
      acc_p <= next_acc_p;
      n <= next_n;
      o_current <= next_cur_out;
      o_power <= next_pwr_out;
      o_conv_ready <= next_rdy;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_CALC_AFTER_BOTH: assert property (go1 |-> $past(bus_done))
    else $error("calc began without a bus result");
  AST_PWR_LATEST_BUS: assert property (go2 |-> bus_raw == $past(i_adc_data, 2))
    else $error("power not using latest bus result");
  AST_ZERO_CAL: assert property ((go2 && cal == 16'h0000) |-> pwr_comb == 16'sh0000)
    else $error("power nonzero with zero calibration");
  AST_HOLD_INTERMEDIATE: assert property (
    (go2 && !n_last) |=> $stable(o_current) && $stable(o_power))
    else $error("intermediate value published");
  AST_AVG1_DIRECT: assert property ((go2 && avg_log == 4'h0) |-> n_last)
    else $error("single sample run not published");
  AST_ACC_ADD: assert property (
    (go2 && !n_last && !restart) |=> n == $past(n) + 11'h001 && acc_c == $past(sum_c))
    else $error("sample not accumulated");
  AST_PUBLISH: assert property (
    (go2 && n_last && !restart) |=> o_conv_ready && n == 11'h000 && acc_c == 26'h0000000
    && o_current == $past(avg_c[DW-1:0]))
    else $error("average not published or accumulator not cleared");
  // a host config write in the start cycle legally drops the start, so it is left out
  AST_SEQ_NO_WAIT: assert property (
    (done_now && o_adc_sel == SEL_SHUNT && !restart ##1 !restart)
    |=> o_adc_start && o_adc_sel == SEL_BUS)
    else $error("bus conversion delayed");
  AST_TEMP_THEN_SHUNT: assert property (
    (done_now && o_adc_sel == SEL_TEMP && o_mode[1] && !restart ##1 !restart)
    |=> o_adc_start && o_adc_sel == SEL_SHUNT)
    else $error("sequence did not return to shunt");
  AST_TRIG_STOP: assert property (
    (done_now && o_adc_sel == SEL_TEMP && samp_last && o_mode == MODE_TRIG && !restart)
    |=> state == ST_IDLE && !o_adc_start)
    else $error("triggered run did not stop");

  CV_PUBLISH_AVG: cover property (go2 && n_last && avg_log != 4'h0);
  CV_TRIG_DONE: cover property (o_mode == MODE_TRIG && $fell(o_busy));
  CV_HOST_WRITE: cover property (restart);
  CV_HOST_READ: cover property (rd_ev && cmd[2:0] == A_CUR);
endmodule

// ---- core/cpe_spi.sv ----
// cpe_spi: serial port of the engine, all logic on the host's link clock
// assumes: mode 0 frames of command, turnaround byte, 16 data bits;
// words cross to the core by toggle handshakes
`timescale 1ns/10ps
module cpe_spi
  import cpe_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_hold,
  input wire logic i_clr_cnt,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [7:0] o_cmd,
  output logic o_req_tgl,
  input wire logic i_ack_tgl,
  input wire logic [DW-1:0] i_rdata,
  output logic [DW-1:0] o_wdata,
  output logic o_wr_tgl
);
  logic [4:0] cnt, next_cnt; // bit position within the frame
  logic [DW-1:0] rx, next_rx; // receive shifter
  logic [DW-1:0] tx, next_tx; // transmit shifter
  logic [DW-1:0] next_wdata;
  logic [7:0] next_cmd;
  logic next_req_tgl, next_wr_tgl;
  logic [2:0] ack_s, next_ack_s; // ack toggle synchroniser
  logic ack_ok; // core answered this frame's command

  //////////////////////////////////////////////////////////////////////
  // frame decode; counter wraps so frames run back to back under low cs
  always_comb
  begin
    next_ack_s = {ack_s[1:0], i_ack_tgl};
    ack_ok = (ack_s[1] == ack_s[2]) && (ack_s[2] == o_req_tgl);
    next_cnt = cnt + 5'h01;
    next_rx = {rx[DW-2:0], i_mosi};
    next_tx = {tx[DW-2:0], 1'b0};
    next_cmd = o_cmd;
    next_req_tgl = o_req_tgl;
    next_wdata = o_wdata;
    next_wr_tgl = o_wr_tgl;
    if (cnt == CMD_LAST)
    begin
      next_cmd = next_rx[7:0];
      next_req_tgl = ~o_req_tgl; // ask the core for read data
    end
    if (cnt == TA_LAST)
    begin
      // a late core answer reads as zero rather than stale data
      next_tx = ack_ok ? i_rdata : {DW{1'b0}};
    end
    if (cnt == DAT_LAST)
    begin
      next_wdata = next_rx;
      if (o_cmd[CMD_WR_BIT])
      begin
        next_wr_tgl = ~o_wr_tgl;
      end
    end
  end

  // counter also clears while chip select is high
  always_ff @(posedge i_sclk or posedge i_clr_cnt)
  begin
    if (i_clr_cnt)
      cnt <= 5'h00;
    else
      cnt <= next_cnt;
  end

  // toggles clear only with the core so both sides stay paired
  always_ff @(posedge i_sclk or posedge i_hold)
  begin
    if (i_hold)
    begin
      rx <= 16'h0000;
      tx <= 16'h0000;
      o_cmd <= 8'h00;
      o_req_tgl <= 1'b0;
      o_wdata <= 16'h0000;
      o_wr_tgl <= 1'b0;
      ack_s <= 3'h0;
    end
    else
    begin
      rx <= next_rx;
      tx <= next_tx;
      o_cmd <= next_cmd;
      o_req_tgl <= next_req_tgl;
      o_wdata <= next_wdata;
      o_wr_tgl <= next_wr_tgl;
      ack_s <= next_ack_s;
    end
  end

  // data changes on the falling edge, host samples on the rising one
  always_ff @(negedge i_sclk or posedge i_hold)
  begin
    if (i_hold)
      o_miso <= 1'b0;
    else
      o_miso <= tx[DW-1];
  end

  assign o_miso_oe = ~i_cs_n; // drive only while selected
endmodule

// ---- include/cpe_pkg.sv ----
// cpe_pkg: constants and types of the current and power calc engine
// assumes: 16-bit converter words, host frames of 32 link clock bits
package cpe_pkg;
  localparam int DW = 16; // data word width
  localparam logic [4:0] CMD_LAST = 5'h07; // bit index ending the command byte
  localparam logic [4:0] TA_LAST = 5'h0f; // bit index ending the turnaround byte
  localparam logic [4:0] DAT_LAST = 5'h1f; // bit index ending the data word
  localparam int CMD_WR_BIT = 7; // command bit: 1 = write
  localparam logic [2:0] A_CFG = 3'h0; // configuration
  localparam logic [2:0] A_CAL = 3'h1; // shunt calibration
  localparam logic [2:0] A_CUR = 3'h2; // averaged current
  localparam logic [2:0] A_PWR = 3'h3; // averaged power
  localparam logic [2:0] A_SHUNT = 3'h4; // last shunt result
  localparam logic [2:0] A_BUS = 3'h5; // last bus result
  localparam logic [2:0] A_TEMP = 3'h6; // last temperature result
  localparam int CFG_MODE_LSB = 0; // 2-bit mode field
  localparam int CFG_RANGE_BIT = 4; // shunt range select
  localparam int CFG_AVG_LSB = 8; // 4-bit log2 of averaging count
  localparam logic [15:0] CFG_RST = 16'h0002; // continuous, range 0, no averaging
  localparam logic [15:0] CAL_RST = 16'h0000; // calibration after reset
  localparam logic [1:0] MODE_OFF = 2'h0; // shutdown
  localparam logic [1:0] MODE_TRIG = 2'h1; // one averaging run per write
  localparam logic [1:0] MODE_CONT = 2'h2; // endless runs
  localparam logic [3:0] AVG_LOG_MAX = 4'ha; // 1024 samples
  localparam logic [1:0] SEL_SHUNT = 2'h0; // converter input codes
  localparam logic [1:0] SEL_BUS = 2'h1;
  localparam logic [1:0] SEL_TEMP = 2'h2;
  localparam int CUR_SHIFT = 11; // current scaling shift
  localparam int RANGE_SHIFT = 2; // 5 uV versus 1.25 uV weight
  localparam int PWR_SHIFT = 14; // power scaling shift
  localparam int ACC_W = 26; // 16 bits plus 1024 sample growth
  localparam int NW = 11; // sample counter width
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b100
  } cpe_seq_t;
endpackage
